// ==== common/zeroing_pkg.sv ====
// Constants, field layouts and types for the return-to-zero controller
// ----------------------------------------------------------------------
// Summary of operation
// - zeroing moves in full steps, one coil driven, the other left open
// - back voltage on the open coil integrates into a 15-bit accumulator
// - command bit D1 enables or disables zeroing, D0 picks gauge 0 or 1
// - window code 00 gives [7:0], 01 gives [11:4], 10 and 11 give [14:8]
// - window code may change mid-zeroing without disturbing the movement
// - reported value is previous step's result; all ones during first step
// - D4 zero stops on stall; D4 one keeps moving until commanded off
// - configuration D3:D0 picks step dwell from sixteen values, default 0101
// - blanking after each step change is 512 us, or 768 us with D4 set
// - accumulator is compared with threshold at end of each full step
// - two's complement, bit 14 is sign; sign one means stall, threshold 0
// - integrator and accumulator restart after every full step
// - each step preloads accumulator with minus sixteen times preload, minus one
// - after reset the preload gives -1, so a step whose integral is not positive counts as stall
// - address 100 is the zeroing command, 101 the configuration; write only
// - gauge zeroing flag holds until message after stall, or commanded off
// - accumulator status reads zero after reset, keeps last result after stop
// ----------------------------------------------------------------------
`default_nettype none

package zeroing_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int GAUGES   = 2;
    localparam int ACC_W    = 15;
    localparam int WORD_W   = 16;
    localparam int TIMER_W  = 21;

    // ----------------------------------------------------------------
    // serial addresses and field positions
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_ZERO_CMD = 3'h4;
    localparam logic [2:0] ADDR_ZERO_CFG = 3'h5;
    localparam int ADDR_LSB        = 13;
    localparam int CMD_GAUGE_BIT   = 0;
    localparam int CMD_ENABLE_BIT  = 1;
    localparam int CMD_WIN_LSB     = 2;
    localparam int CMD_UNCOND_BIT  = 4;
    localparam int CMD_RSVD_LSB    = 5;
    localparam int CFG_STEP_LSB    = 0;
    localparam int CFG_BLANK_BIT   = 4;
    localparam int CFG_PRELOAD_LSB = 5;
    localparam int ST_WIN_LSB      = 8;
    localparam int ST_FLAG0_BIT    = 2;

    // ----------------------------------------------------------------
    // reset values and window codes
    // ----------------------------------------------------------------
    localparam logic [3:0] STEP_SEL_RESET = 4'h5;
    localparam logic       BLANK_RESET    = 1'b0;
    localparam logic [7:0] PRELOAD_RESET  = 8'h00;
    localparam logic [1:0] WIN_RESET      = 2'h0;
    localparam logic [1:0] WIN_LOW        = 2'h0;
    localparam logic [1:0] WIN_MID        = 2'h1;

    // ----------------------------------------------------------------
    // timing: step dwell table in units of 10 us
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int STEP_UNIT_NS   = 10000;
    localparam int BLANK_SHORT_US = 512;
    localparam int BLANK_LONG_US  = 768;
    localparam int STEP_UNIT_CYCLES =
        (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_SHORT_CYCLES =
        (BLANK_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_LONG_CYCLES =
        (BLANK_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [12:0] STEP_TIME_10US [16] = '{
        13'd486,  13'd486,  13'd896,  13'd1306, 13'd1715, 13'd2125,
        13'd2534, 13'd2944, 13'd3354, 13'd3763, 13'd4173, 13'd4582,
        13'd4992, 13'd5402, 13'd5811, 13'd6221};

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_BLANK,
        PH_INTEGRATE
    } step_phase_t;

endpackage

`default_nettype wire

// ==== core/step_integrator.sv ====
// Saturating up/down accumulator fed by a sigma-delta back-voltage stream
`default_nettype none

module step_integrator (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           load,
    input  wire logic [zeroing_pkg::ACC_W-1:0]  preload,
    input  wire logic                           enable,
    input  wire logic                           sample,
    output logic      [zeroing_pkg::ACC_W-1:0]  acc
);
    import zeroing_pkg::*;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
    } integ_t;

    integ_t q;
    integ_t d;

    localparam logic [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
    localparam logic [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};

    // saturation keeps a long free-running step from wrapping the sign
    always_comb begin
        d = q;
        if (load) begin
            d.acc = preload;
        end else if (enable && sample && q.acc != ACC_MAX) begin
            d.acc = q.acc + 15'h0001;
        end else if (enable && !sample && q.acc != ACC_MIN) begin
            d.acc = q.acc - 15'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign acc = q.acc;

endmodule

`default_nettype wire

// ==== core/serial_link.sv ====
// Serial shift logic on the host's clock: word capture and status shift-out
`default_nettype none

module serial_link (
    input  wire logic                          serial_clk,
    input  wire logic                          rst,
    input  wire logic                          chip_select_n,
    input  wire logic                          serial_in,
    input  wire logic [zeroing_pkg::WORD_W-1:0] status_word,
    output logic                               serial_out,
    output logic                               serial_out_oe_n,
    output logic      [zeroing_pkg::WORD_W-1:0] word_data,
    output logic                               word_toggle,
    output logic                               word_complete
);
    import zeroing_pkg::*;

    typedef struct packed {
        logic [WORD_W-1:0] shift;
        logic [WORD_W-1:0] word;
        logic              complete;
        logic              toggle;
    } link_t;

    // frame state is cleared by the select going high, sclk may stop then
    typedef struct packed {
        logic [3:0] count;
        logic       over;
        logic       done;
    } frame_t;

    link_t  lq;
    link_t  ld;
    frame_t fq;
    frame_t fd;
    logic   frame_rst;

    assign frame_rst = rst | chip_select_n;

    always_comb begin
        ld = lq;
        fd = fq;
        ld.shift = {lq.shift[WORD_W-2:0], serial_in};
        fd.count = fq.count + 4'h1;
        if (fq.count == 4'hf) begin
            fd.over     = 1'b1;
            fd.done     = 1'b1;
            ld.word     = {lq.shift[WORD_W-2:0], serial_in};
            ld.complete = 1'b1;
            // one toggle per frame tells the core a word exists
            if (!fq.done) begin
                ld.toggle = ~lq.toggle;
            end
        end else if (fq.count == 4'h0) begin
            ld.complete = 1'b0;
        end
    end

    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    always_ff @(posedge serial_clk or posedge frame_rst) begin
        if (frame_rst) begin
            fq <= '0;
        end else begin
            fq <= fd;
        end
    end

    // status first, then the bits shifted in sixteen clocks earlier
    assign serial_out      = fq.over ? lq.shift[WORD_W-1] : status_word[4'hf - fq.count];
    assign serial_out_oe_n = chip_select_n;
    assign word_data       = lq.word;
    assign word_toggle     = lq.toggle;
    assign word_complete   = lq.complete;

endmodule

`default_nettype wire

// ==== core/return_to_zero_core.sv ====
// Return-to-zero controller: command decode, step timing, stall decision
`default_nettype none

module return_to_zero_core #(
    parameter int unsigned step_unit_cycles   = zeroing_pkg::STEP_UNIT_CYCLES,
    parameter int unsigned blank_short_cycles = zeroing_pkg::BLANK_SHORT_CYCLES,
    parameter int unsigned blank_long_cycles  = zeroing_pkg::BLANK_LONG_CYCLES
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          serial_clk,
    input  wire logic                          chip_select_n,
    input  wire logic                          serial_in,
    output logic                               serial_out,
    output logic                               serial_out_oe_n,
    input  wire logic [zeroing_pkg::GAUGES-1:0] back_voltage_a,
    input  wire logic [zeroing_pkg::GAUGES-1:0] back_voltage_b,
    output logic      [zeroing_pkg::GAUGES-1:0] coil_a_drive,
    output logic      [zeroing_pkg::GAUGES-1:0] coil_a_positive,
    output logic      [zeroing_pkg::GAUGES-1:0] coil_b_drive,
    output logic      [zeroing_pkg::GAUGES-1:0] coil_b_positive,
    output logic      [zeroing_pkg::GAUGES-1:0] zeroing_busy
);
    import zeroing_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                          cs_meta;
        logic                          cs_sync;
        logic                          cs_prev;
        logic                          tgl_meta;
        logic                          tgl_sync;
        logic                          tgl_seen;
        logic [GAUGES-1:0]             bva_meta;
        logic [GAUGES-1:0]             bva_sync;
        logic [GAUGES-1:0]             bvb_meta;
        logic [GAUGES-1:0]             bvb_sync;
        logic [3:0]                    step_sel;
        logic                          blank_long;
        logic [7:0]                    preload;
        logic [1:0]                    win;
        logic                          shown;
        logic [GAUGES-1:0]             active;
        logic [GAUGES-1:0]             flag;
        logic [GAUGES-1:0]             detected;
        logic [GAUGES-1:0]             uncond;
        logic [GAUGES-1:0][1:0]        coil;
        step_phase_t [GAUGES-1:0]      phase;
        logic [GAUGES-1:0][TIMER_W-1:0] timer;
        logic [GAUGES-1:0][ACC_W-1:0]  report;
        logic [WORD_W-1:0]             snap;
        logic [GAUGES-1:0]             a_drv;
        logic [GAUGES-1:0]             a_pos;
        logic [GAUGES-1:0]             b_drv;
        logic [GAUGES-1:0]             b_pos;
    } state_t;

    localparam state_t STATE_RESET = '{
        cs_meta:    1'b1,
        cs_sync:    1'b1,
        cs_prev:    1'b1,
        step_sel:   STEP_SEL_RESET,
        blank_long: BLANK_RESET,
        preload:    PRELOAD_RESET,
        win:        WIN_RESET,
        phase:      {GAUGES{PH_IDLE}},
        default:    '0
    };

    state_t q;
    state_t d;

    logic [WORD_W-1:0]             link_word;
    logic                          link_toggle;
    logic                          link_complete;
    logic [GAUGES-1:0]             acc_load;
    logic [GAUGES-1:0]             acc_en;
    logic [GAUGES-1:0]             acc_sample;
    logic [GAUGES-1:0][ACC_W-1:0]  acc;
    logic [ACC_W-1:0]              preload_init;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [TIMER_W-1:0] step_len(input logic [3:0] sel);
        int unsigned t;
        t = int'(STEP_TIME_10US[sel]) * step_unit_cycles;
        return t[TIMER_W-1:0];
    endfunction

    function automatic logic [TIMER_W-1:0] blank_len(input logic long_sel);
        int unsigned t;
        t = long_sel ? blank_long_cycles : blank_short_cycles;
        return t[TIMER_W-1:0];
    endfunction

    // preload as minus sixteen times value minus one
    function automatic logic [ACC_W-1:0] initial_value(input logic [7:0] pv);
        return ~{3'b000, pv, 4'h0};
    endfunction

    function automatic logic [7:0] window_pick(input logic [ACC_W-1:0] v,
                                               input logic [1:0]       code);
        logic [7:0] w;
        case (code)
            WIN_LOW: w = v[7:0];
            WIN_MID: w = v[11:4];
            default: w = {1'b0, v[14:8]};
        endcase
        return w;
    endfunction

    // ----------------------------------------------------------------
    // serial link, clocked by the host
    // ----------------------------------------------------------------
    serial_link u_link (
        .serial_clk      (serial_clk),
        .rst             (rst),
        .chip_select_n   (chip_select_n),
        .serial_in       (serial_in),
        .status_word     (q.snap),
        .serial_out      (serial_out),
        .serial_out_oe_n (serial_out_oe_n),
        .word_data       (link_word),
        .word_toggle     (link_toggle),
        .word_complete   (link_complete)
    );

    // ----------------------------------------------------------------
    // per-gauge back-voltage integrators
    // ----------------------------------------------------------------
    assign preload_init = initial_value(q.preload);

    for (genvar g = 0; g < GAUGES; g++) begin : g_integ
        step_integrator u_integ (
            .clk     (clk),
            .rst     (rst),
            .load    (acc_load[g]),
            .preload (preload_init),
            .enable  (acc_en[g]),
            .sample  (acc_sample[g]),
            .acc     (acc[g])
        );
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic              frame_end;
        logic              msg;
        logic [2:0]        addr;
        logic [12:0]       data;
        logic              cmd_ok;
        logic              cfg_ok;
        logic              sel;
        logic [TIMER_W-1:0] len;
        logic [WORD_W-1:0] status_now;
        frame_end  = 1'b0;
        msg        = 1'b0;
        addr       = '0;
        data       = '0;
        cmd_ok     = 1'b0;
        cfg_ok     = 1'b0;
        sel        = 1'b0;
        len        = '0;
        status_now = '0;
        d          = q;
        acc_load   = '0;
        acc_en     = '0;
        acc_sample = '0;

        // two-stage synchronisers for the pins and the word toggle
        d.cs_meta  = chip_select_n;
        d.cs_sync  = q.cs_meta;
        d.cs_prev  = q.cs_sync;
        d.tgl_meta = link_toggle;
        d.tgl_sync = q.tgl_meta;
        d.bva_meta = back_voltage_a;
        d.bva_sync = q.bva_meta;
        d.bvb_meta = back_voltage_b;
        d.bvb_sync = q.bvb_meta;

        // word and complete flag are static while select is high
        frame_end = q.cs_sync & ~q.cs_prev;
        if (frame_end) begin
            d.tgl_seen = q.tgl_sync;
            msg        = (q.tgl_sync != q.tgl_seen) & link_complete;
        end
        addr = link_word[WORD_W-1:ADDR_LSB];
        data = link_word[ADDR_LSB-1:0];
        // nonzero reserved bits drop the command
        cmd_ok = msg && addr == ADDR_ZERO_CMD && data[12:CMD_RSVD_LSB] == 8'h00;
        cfg_ok = msg && addr == ADDR_ZERO_CFG;
        sel    = data[CMD_GAUGE_BIT];

        if (cfg_ok) begin
            d.step_sel   = data[CFG_STEP_LSB +: 4];
            d.blank_long = data[CFG_BLANK_BIT];
            d.preload    = data[CFG_PRELOAD_LSB +: 8];
        end

        // window change never touches the step engines
        if (cmd_ok) begin
            d.win   = data[CMD_WIN_LSB +: 2];
            d.shown = sel;
        end

        for (int g = 0; g < GAUGES; g++) begin
            // flag drops at the message after a stall
            if (msg && q.detected[g]) begin
                d.flag[g]     = 1'b0;
                d.detected[g] = 1'b0;
            end

            // undriven coil is the one integrated
            acc_sample[g] = q.coil[g][0] ? q.bva_sync[g] : q.bvb_sync[g];
            len           = step_len(q.step_sel);

            case (q.phase[g])
                PH_IDLE: begin
                    d.timer[g] = '0;
                end
                PH_BLANK: begin
                    d.timer[g] = q.timer[g] + 21'h000001;
                    if (q.timer[g] >= blank_len(q.blank_long) - 21'h000001) begin
                        d.phase[g] = PH_INTEGRATE;
                    end
                end
                PH_INTEGRATE: begin
                    acc_en[g]  = 1'b1;
                    d.timer[g] = q.timer[g] + 21'h000001;
                    if (q.timer[g] >= len - 21'h000001) begin
                        acc_en[g] = 1'b0;
                        d.report[g] = acc[g];
                        if (acc[g][ACC_W-1] && !q.uncond[g]) begin
                            d.active[g]   = 1'b0;
                            d.phase[g]    = PH_IDLE;
                            d.detected[g] = 1'b1;
                        end else begin
                            d.coil[g]  = q.coil[g] - 2'h1;
                            d.timer[g] = '0;
                            d.phase[g] = PH_BLANK;
                            acc_load[g] = 1'b1;
                        end
                    end
                end
                default: begin
                    d.phase[g] = PH_IDLE;
                end
            endcase

            // enable or disable the selected gauge
            if (cmd_ok && sel == 1'(g)) begin
                d.uncond[g] = data[CMD_UNCOND_BIT];
                if (data[CMD_ENABLE_BIT] && !q.active[g]) begin
                    d.active[g]   = 1'b1;
                    d.flag[g]     = 1'b1;
                    d.detected[g] = 1'b0;
                    d.phase[g]    = PH_BLANK;
                    d.timer[g]    = '0;
                    d.report[g]   = '1;
                    acc_load[g]   = 1'b1;
                end else if (!data[CMD_ENABLE_BIT]) begin
                    d.active[g]   = 1'b0;
                    d.flag[g]     = 1'b0;
                    d.detected[g] = 1'b0;
                    d.phase[g]    = PH_IDLE;
                end
            end

            // exactly one coil energised while stepping
            d.a_drv[g] = d.phase[g] != PH_IDLE && !d.coil[g][0];
            d.b_drv[g] = d.phase[g] != PH_IDLE && d.coil[g][0];
            d.a_pos[g] = !d.coil[g][1];
            d.b_pos[g] = !d.coil[g][1];
        end

        // status window, zero after reset, last result after stop
        status_now[ST_WIN_LSB +: 8] = window_pick(q.report[q.shown], q.win);
        status_now[ST_FLAG0_BIT +: GAUGES] = q.flag;
        // snapshot frozen while a frame is open
        if (q.cs_sync) begin
            d.snap = status_now;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // reset preload value zero gives -1
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    assign coil_a_drive    = q.a_drv;
    assign coil_a_positive = q.a_pos;
    assign coil_b_drive    = q.b_drv;
    assign coil_b_positive = q.b_pos;
    assign zeroing_busy    = q.active;

endmodule

`default_nettype wire

// ==== verif/return_to_zero_checker.sv ====
// port assertions for the return-to-zero controller
`default_nettype none
module return_to_zero_checker (
    input wire logic                            clk,
    input wire logic                            rst,
    input wire logic                            chip_select_n,
    input wire logic                            serial_out_oe_n,
    input wire logic [zeroing_pkg::GAUGES-1:0]  coil_a_drive,
    input wire logic [zeroing_pkg::GAUGES-1:0]  coil_a_positive,
    input wire logic [zeroing_pkg::GAUGES-1:0]  coil_b_drive,
    input wire logic [zeroing_pkg::GAUGES-1:0]  coil_b_positive,
    input wire logic [zeroing_pkg::GAUGES-1:0]  zeroing_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_one_coil; (coil_a_drive & coil_b_drive) == 2'h0; endproperty
    property p_busy_drive;
        (zeroing_busy & ~(coil_a_drive ^ coil_b_drive)) == 2'h0;
    endproperty
    property p_idle_off; (~zeroing_busy & (coil_a_drive | coil_b_drive)) == 2'h0; endproperty
    property p_oe; serial_out_oe_n == chip_select_n; endproperty
    property p_first; $rose(zeroing_busy[0]) |-> coil_a_drive[0] && coil_a_positive[0]; endproperty
    property p_after_apos;
        zeroing_busy[0] && $past(zeroing_busy[0]) && $past(coil_a_drive[0])
            && $past(coil_a_positive[0]) && coil_b_drive[0] |-> !coil_b_positive[0];
    endproperty
    property p_after_aneg;
        zeroing_busy[0] && $past(zeroing_busy[0]) && $past(coil_a_drive[0])
            && !$past(coil_a_positive[0]) && coil_b_drive[0] |-> coil_b_positive[0];
    endproperty
    property p_hold;
        zeroing_busy[0] && $changed(coil_a_drive[0]) |=> $stable(coil_a_drive[0])[*8];
    endproperty
    property p_start;
        $rose(zeroing_busy[1]) |-> $past(chip_select_n, 2) && $past(chip_select_n, 3);
    endproperty
    a_one_coil: assert property (p_one_coil)
        else $error("both coils of a gauge driven");
    a_busy_drive: assert property (p_busy_drive)
        else $error("zeroing gauge lacks exactly one driven coil");
    a_idle_off: assert property (p_idle_off)
        else $error("coil driven while gauge idle");
    a_oe: assert property (p_oe)
        else $error("serial output enable does not follow select");
    a_first: assert property (p_first)
        else $error("first full step not coil a positive");
    a_after_apos: assert property (p_after_apos)
        else $error("wrong step after coil a positive");
    a_after_aneg: assert property (p_after_aneg)
        else $error("wrong step after coil a negative");
    a_hold: assert property (p_hold)
        else $error("full step shorter than eight cycles");
    a_start: assert property (p_start)
        else $error("zeroing started without a finished frame");
    c_stop: cover property ($fell(zeroing_busy[0]));
    c_start1: cover property ($rose(zeroing_busy[1]));
    c_bpos: cover property (zeroing_busy[0] && coil_b_drive[0] && coil_b_positive[0]);
endmodule
bind return_to_zero_core return_to_zero_checker return_to_zero_checker_i (.clk, .rst,
    .chip_select_n, .serial_out_oe_n, .coil_a_drive, .coil_a_positive, .coil_b_drive,
    .coil_b_positive, .zeroing_busy);
`default_nettype wire

// ==== verif/gauge_motor_model.sv ====
// motor coil model: back voltage streams for a running or stalled pointer
`default_nettype none
module gauge_motor_model (
    input  wire logic       clk,
    input  wire logic [1:0] stalled,
    input  wire logic [1:0] coil_a_drive,
    input  wire logic [1:0] coil_b_drive,
    output logic      [1:0] back_voltage_a,
    output logic      [1:0] back_voltage_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic toggle_q = 1'b0;
    always @(posedge clk) toggle_q <= ~toggle_q;
    // a driven coil carries only switching noise, so never a steady level
    always_comb begin
        for (int g = 0; g < 2; g++) begin
            back_voltage_a[g] = coil_a_drive[g] ? toggle_q : ~stalled[g];
            back_voltage_b[g] = coil_b_drive[g] ? toggle_q : ~stalled[g];
        end
    end
endmodule
`default_nettype wire

// ==== verif/test_return_to_zero_core.sv ====
// self-checking bench for the return-to-zero controller
`default_nettype none
module test_return_to_zero_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, serial_clk = 1'b0, chip_select_n = 1'b1;
    logic        serial_in = 1'b0, serial_out, serial_out_oe_n;
    logic [1:0]  stalled = 2'h0, bv_a, bv_b, ca_d, ca_p, cb_d, cb_p, busy;
    logic [15:0] st;
    logic [31:0] rnd = 32'h99e1;
    int          n_errors = 0;
    int          samples_checked = 0;
    always #20 clk = ~clk;
    return_to_zero_core #(.step_unit_cycles(1), .blank_short_cycles(4),
        .blank_long_cycles(6)) return_to_zero_core_i (.clk, .rst, .serial_clk,
        .chip_select_n, .serial_in, .serial_out, .serial_out_oe_n, .back_voltage_a(bv_a),
        .back_voltage_b(bv_b), .coil_a_drive(ca_d), .coil_a_positive(ca_p),
        .coil_b_drive(cb_d), .coil_b_positive(cb_p), .zeroing_busy(busy));
    gauge_motor_model gauge_motor_model_i (.clk, .stalled, .coil_a_drive(ca_d),
        .coil_b_drive(cb_d), .back_voltage_a(bv_a), .back_voltage_b(bv_b));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] win(input logic [14:0] a, input logic [1:0] c);
        return c == 2'h0 ? a[7:0] : c == 2'h1 ? a[11:4] : {1'b0, a[14:8]};
    endfunction
    // one 16-bit frame out, status word in
    task automatic xfer(input logic [2:0] addr, input logic [12:0] data);
        logic [15:0] w;
        w = {addr, data};
        @(posedge clk) #2 chip_select_n = 1'b0;
        #130;
        for (int k = 15; k >= 0; k--) begin
            serial_in = w[k];
            st[k] = serial_out;
            #24 serial_clk = 1'b1;
            #24 serial_clk = 1'b0;
        end
        @(posedge clk) #2 chip_select_n = 1'b1;
        serial_in = ~serial_in;
        repeat (8) @(posedge clk) #2;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_busy(input int g, input logic v, input int lim);
        int n;
        n = 0;
        while (busy[g] !== v && n < lim) begin
            @(posedge clk) #2;
            n++;
        end
        check("busy", {15'h0, v}, {15'h0, busy[g]});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        stop_test();
    end
    initial begin
        logic [1:0] p;
        int t;
        repeat (3) @(posedge clk);
        #2 rst = 1'b0;
        repeat (4) @(posedge clk);
        xfer(3'h0, 13'h0000);
        check("status after reset", 16'h0000, st);
        $display("reset test done");
        rnd = lfsr(rnd);
        xfer(3'h5, {4'h0, rnd[3:0], rnd[4], 3'h0, rnd[5]});
        xfer(3'h4, 13'h0002);
        wait_busy(0, 1'b1, 10);
        p = 2'h0;
        for (int c = 1; c <= 5; c++) begin
            xfer(3'h4, {9'h0, c[1:0], 2'h2});
            check("first step window", {win(15'h7fff, p), 8'h04}, st);
            p = c[1:0];
        end
        check("busy kept", 16'h0001, {15'h0, busy[0]});
        repeat (500) @(posedge clk);
        xfer(3'h0, 13'h0000);
        check("moving sign", 16'h0004, st & 16'h4004);
        stalled = 2'h1;
        wait_busy(0, 1'b0, 1100);
        xfer(3'h0, 13'h0000);
        check("stall sign", 16'h4004, st & 16'h4004);
        xfer(3'h5, 13'h00a0);
        xfer(3'h0, 13'h0000);
        check("flag cleared", 16'h4000, st & 16'h4004);
        $display("zeroing test done");
        xfer(3'h4, 13'h0023);
        check("reserved refused", 16'h0000, {14'h0, busy});
        stalled = 2'h3;
        xfer(3'h4, 13'h0013);
        wait_busy(1, 1'b1, 10);
        @(ca_d[1]) #2 p[0] = ca_d[1];
        t = 0;
        while (ca_d[1] === p[0] && t < 600) begin
            @(posedge clk) #2;
            t++;
        end
        check("step cycles", 16'd486, 16'(t));
        repeat (1500) @(posedge clk) #2;
        check("unconditional", 16'h0002, {14'h0, busy});
        xfer(3'h4, 13'h0001);
        wait_busy(1, 1'b0, 10);
        $display("unconditional test done");
        stop_test();
    end
endmodule
`default_nettype wire
